// ### common/rio_pkg.sv
package rio_pkg;

	// Clock and printed link timings
	localparam int unsigned CLK_MHZ       = 25;
	localparam int unsigned T_STARTUP_US  = 10000;
	localparam int unsigned T_STD_US      = 19200;
	localparam int unsigned T_FAST_US     = 3000;
	localparam int unsigned LOSS_FRAMES   = 2;
	localparam int unsigned STARTUP_CYC   = T_STARTUP_US * CLK_MHZ;
	localparam int unsigned LOSS_STD_CYC  = LOSS_FRAMES * T_STD_US * CLK_MHZ;
	localparam int unsigned LOSS_FAST_CYC = LOSS_FRAMES * T_FAST_US * CLK_MHZ;

	// Word area and unit numbering
	localparam logic [7:0] WORD_AREA_BASE = 8'h1e;
	localparam logic [7:0] WORD_AREA_LAST = 8'h31;
	localparam logic [3:0] UNIT_MAX       = 4'h9;
	localparam logic [1:0] SYNC_DONE      = 2'h2;

	// Register byte offsets
	localparam logic [7:0] REG_CFG   = 8'h00;
	localparam logic [7:0] REG_STS   = 8'h04;
	localparam logic [7:0] REG_MASK  = 8'h08;
	localparam logic [7:0] REG_STAT  = 8'h0c;
	localparam logic [7:0] REG_IN0   = 8'h10;
	localparam logic [7:0] REG_OUT0  = 8'h20;
	localparam logic [7:0] REG_BANK  = 8'hf0;

	// Switch pin positions on the raw switch vector
	localparam int unsigned SW_FAST = 0;
	localparam int unsigned SW_CLR  = 1;
	localparam int unsigned SW_FBIT = 2;
	localparam int unsigned SW_EN1  = 3;
	localparam int unsigned SW_EN2  = 4;
	localparam int unsigned FLAG_BIT = 15;

	typedef struct packed {
		logic [1:0] lamp_en;
		logic       fbit;
		logic       clr;
		logic       fast;
		logic [3:0] unit;
	} rio_cfg_t;

	// Switches 4 and 5 on, all others off, unit 0
	localparam rio_cfg_t CFG_RESET = '{lamp_en: 2'h3, fbit: 1'b0, clr: 1'b0,
		fast: 1'b0, unit: 4'h0};

	typedef enum logic [1:0] {
		PH_SYNC = 2'b01,
		PH_RUN  = 2'b10
	} rio_phase_t;

endpackage

// ### tb/rio_term_model.sv
`timescale 1ns/1ps
module rio_term_model #(
	parameter int unsigned N = 2
) (
	input  wire logic               i_clk,  // System clock
	input  wire logic [N-1:0]       i_req,  // Send one frame for word i
	input  wire logic               i_bad,  // Frame fails its checks
	input  wire logic               i_fast, // Terminal delay setting
	input  wire logic [15:0]        i_word, // Frame payload
	output logic      [N-1:0]       o_stb,  // Frame complete
	output logic      [N-1:0]       o_err,  // Frame bad
	output logic      [N-1:0]       o_fast, // Delay used by the terminal
	output logic      [N-1:0][15:0] o_data  // Frame payload
);
	initial
	begin
		o_stb = '0;
		o_err = '0;
		o_fast = '0;
		o_data = '0;
	end
	// Qualifiers flip between frames so a design reading them without stb is caught
	always @(posedge i_clk)
	begin
		o_stb <= i_req;
		for (int i = 0; i < N; i++)
		begin
			o_err[i] <= i_req[i] ? i_bad : ~o_err[i];
			o_fast[i] <= i_req[i] ? i_fast : ~o_fast[i];
			o_data[i] <= i_req[i] ? i_word : ~o_data[i];
		end
	end
endmodule

// ### tb/tb_rio_link_unit.sv
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin num_errors++; \
	$display("BAD %s exp %h got %h", nm, ex, got); end end
module tb_rio_link_unit;
	logic                i_clk, i_rst_b, i_psel, i_penable, i_pwrite, bad, fast, e;
	logic [3:0]          i_unit_sw;
	logic [4:0]          i_dip_sw;
	logic [1:0]          req, stb, err, rfast, lamp;
	logic [15:0]         word;
	logic [1:0][15:0]    rdata, in_w, tx_w;
	logic [7:0]          i_paddr;
	logic [31:0]         i_pwdata, o_prdata, q;
	logic                o_tx_fast, fl, cl, fb, o_irq, o_pready, o_pslverr;
	int                  num_errors, n_compared;

	rio_term_model #(.N(2)) u_term (.i_clk(i_clk), .i_req(req), .i_bad(bad), .i_fast(fast),
		.i_word(word), .o_stb(stb), .o_err(err), .o_fast(rfast), .o_data(rdata));
	rio_link_unit #(.STARTUP_CYC(50), .LOSS_STD_CYC(100), .LOSS_FAST_CYC(60)) u_dut (
		.i_clk(i_clk), .i_rst_b(i_rst_b), .i_unit_sw(i_unit_sw), .i_dip_sw(i_dip_sw),
		.i_rx_stb(stb), .i_rx_err(err), .i_rx_fast(rfast), .i_rx_data(rdata),
		.o_tx_word(tx_w), .o_tx_fast(o_tx_fast), .o_in_word(in_w), .o_fault_lamp(lamp),
		.o_fast_delay_lamp(fl), .o_clear_lamp(cl), .o_fault_bit_mode_lamp(fb), .o_irq(o_irq),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
		.i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));

	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end

	task automatic results();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// This task changes the switches while reset holds, as a power cycle would
	task automatic boot(input logic [3:0] u, input logic [4:0] d);
		@(posedge i_clk);
		i_rst_b <= 1'b0;
		i_unit_sw <= u;
		i_dip_sw <= d;
		repeat (2) @(posedge i_clk);
		i_rst_b <= 1'b1;
		repeat (5) @(posedge i_clk);
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= w;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clk);
		i_penable <= 1'b1;
		k = 0;
		@(posedge i_clk);
		while (o_pready !== 1'b1)
		begin
			k++;
			if (k > 20)
			begin
				num_errors++;
				results();
			end
			@(posedge i_clk);
		end
		q = o_prdata;
		e = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
		#1;
	endtask

	task automatic frame(input int i, input logic b, input logic f, input logic [15:0] w);
		@(posedge i_clk);
		req[i] <= 1'b1;
		bad <= b;
		fast <= f;
		word <= w;
		@(posedge i_clk);
		req <= '0;
		repeat (2) @(posedge i_clk);
		#1;
	endtask

	initial
	begin
		{i_rst_b, i_psel, i_penable, i_pwrite, bad, fast, req, word} = '0;
		{i_paddr, i_pwdata, i_unit_sw, i_dip_sw, num_errors, n_compared} = '0;
		boot(4'h3, 5'h18);
		apb(1'b0, rio_pkg::REG_CFG, 32'h0);
		`CHK("cfg", {8'h26, 8'h24, 7'h0, 2'h3, 3'h0, 4'h3}, q)
		`CHK("lamps", 3'h0, {fl, cl, fb})
		`CHK("in0", 16'h0, in_w[0])
		i_unit_sw <= 4'h5;
		apb(1'b0, rio_pkg::REG_CFG, 32'h0);
		`CHK("cfg_hold", 8'h83, q[7:0])
		apb(1'b1, rio_pkg::REG_OUT0 + 8'h04, 32'h1234abcd);
		`CHK("tx1", 16'habcd, tx_w[1])
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 33'h100000000, {e, q})
		frame(0, 1'b0, 1'b0, 16'h8001);
		`CHK("in0", 16'h8001, in_w[0])
		frame(1, 1'b0, 1'b0, 16'h00f0);
		frame(1, 1'b0, 1'b1, 16'h1234);
		`CHK("in1_held", 16'h00f0, in_w[1])
		`CHK("lamp", 2'h2, lamp)
		apb(1'b1, rio_pkg::REG_MASK, 32'h2);
		`CHK("irq_on", 1'b1, o_irq)
		apb(1'b1, rio_pkg::REG_STS, 32'h2);
		`CHK("irq_off", 1'b0, o_irq)
		frame(1, 1'b0, 1'b0, 16'h0f0f);
		`CHK("in1_back", 16'h0f0f, in_w[1])
		`CHK("lamp_off", 2'h0, lamp)
		apb(1'b0, rio_pkg::REG_STS, 32'h0);
		`CHK("sts_rec", 1'b1, q[3])
		boot(4'h0, 5'h07);
		`CHK("lamps", 3'h7, {fl, cl, fb})
		`CHK("tx_fast", 1'b1, o_tx_fast)
		frame(0, 1'b0, 1'b1, 16'hffff);
		`CHK("in0_flag", 16'h7fff, in_w[0])
		frame(0, 1'b1, 1'b1, 16'hffff);
		`CHK("in0_clr", 16'h8000, in_w[0])
		`CHK("lamp_dis", 1'b0, lamp[0])
		repeat (60) @(posedge i_clk);
		#1;
		`CHK("in1_start", 16'h8000, in_w[1])
		boot(4'h8, 5'h18);
		apb(1'b0, rio_pkg::REG_CFG, 32'h0);
		`CHK("cfg8", 16'h302e, q[31:16])
		boot(4'h9, 5'h18);
		apb(1'b0, rio_pkg::REG_STS, 32'h0);
		`CHK("unit9", 1'b1, q[4])
		results();
	end
endmodule

// ### verilog/rio_link_unit.sv
// Local design decisions: the APB slave port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - Fault lamp per input word on reception failure
// - Fast-delay lamp follows high-speed delay selection
// - Clear-on-fault lamp follows clear handling setting
// - Fault-bit-mode lamp follows 15-plus-flag mode
// - Unit number sampled only at power-up
// - Words start at 030 plus twice unit
// - Switch 1 picks one delay for all
// - Delay mismatch with terminal is a fault
// - Switch 2 clears or holds inputs on fault
// - Switch 3 makes bit 15 fault flag
// - Switches 4 and 5 gate fault lamps
// - Reset default: switches 4,5 on, rest off
// - Flag off at startup, set after 10 ms
// - Inputs zero until first valid reception
// - Valid reception clears flag, loads fresh inputs
// - No fault detection on output links
// - Output words first, then input words
module rio_link_unit #(
	parameter int unsigned N_IN          = 2,
	parameter int unsigned N_OUT         = 2,
	parameter int unsigned STARTUP_CYC   = rio_pkg::STARTUP_CYC,
	parameter int unsigned LOSS_STD_CYC  = rio_pkg::LOSS_STD_CYC,
	parameter int unsigned LOSS_FAST_CYC = rio_pkg::LOSS_FAST_CYC
) (
	input  wire logic                  i_clk,        // 25 MHz clock
	input  wire logic                  i_rst_b,      // Power-on reset, active low
	input  wire logic [3:0]            i_unit_sw,    // Unit number switch pins
	input  wire logic [4:0]            i_dip_sw,     // Switches 1..5 at bits 0..4
	input  wire logic [N_IN-1:0]       i_rx_stb,     // Received frame complete
	input  wire logic [N_IN-1:0]       i_rx_err,     // Frame failed its checks
	input  wire logic [N_IN-1:0]       i_rx_fast,    // Terminal uses high-speed delay
	input  wire logic [N_IN-1:0][15:0] i_rx_data,    // Received input word
	output logic      [N_OUT-1:0][15:0] o_tx_word,   // Words for output terminals
	output logic                       o_tx_fast,    // Delay for output transmitters
	output logic      [N_IN-1:0][15:0] o_in_word,    // Input words to the controller
	output logic      [N_IN-1:0]       o_fault_lamp, // Input fault lamps
	output logic                       o_fast_delay_lamp,    // High-speed delay lamp
	output logic                       o_clear_lamp,         // Clear-on-fault lamp
	output logic                       o_fault_bit_mode_lamp, // Flag-bit mode lamp
	output logic                       o_irq,        // Interrupt, active high
	input  wire logic                  i_psel,       // APB select
	input  wire logic                  i_penable,    // APB enable
	input  wire logic                  i_pwrite,     // APB write
	input  wire logic [7:0]            i_paddr,      // APB byte address
	input  wire logic [31:0]           i_pwdata,     // APB write data
	output logic      [31:0]           o_prdata,     // APB read data
	output logic                       o_pready,     // APB ready
	output logic                       o_pslverr     // APB error
);

	localparam int unsigned STS_W = 2 * N_IN + 1;
	localparam int unsigned CW    = 24;

	typedef struct packed {
		rio_pkg::rio_phase_t        phase;
		logic [1:0]                 cap_cnt;
		logic [8:0]                 sw1;
		logic [8:0]                 sw2;
		rio_pkg::rio_cfg_t          cfg;
		logic [N_IN-1:0]            seen;
		logic [N_IN-1:0]            fault;
		logic [N_IN-1:0][15:0]      in_word;
		logic [N_IN-1:0][CW-1:0]    tmo;
		logic [N_OUT-1:0][15:0]     out_word;
		logic [STS_W-1:0]           sts;
		logic [STS_W-1:0]           mask;
		logic [N_IN-1:0]            fault_lamp;
		logic                       fast_lamp;
		logic                       clr_lamp;
		logic                       fbit_lamp;
		logic [31:0]                prdata;
	} rio_state_t;

	rio_state_t st_r;
	rio_state_t st_nxt;

	function automatic logic [7:0] base_word(input logic [3:0] unit);
		base_word = rio_pkg::WORD_AREA_BASE + {3'h0, unit, 1'b0};
	endfunction

	function automatic logic addr_ok(input logic [7:0] a);
		logic [7:0] idx;
		idx = {4'h0, a[3:0] >> 2};
		addr_ok = 1'b0;
		if (a[1:0] == 2'h0)
		begin
			if (a == rio_pkg::REG_CFG || a == rio_pkg::REG_STS ||
				a == rio_pkg::REG_MASK || a == rio_pkg::REG_STAT)
				addr_ok = 1'b1;
			else if ((a & rio_pkg::REG_BANK) == rio_pkg::REG_IN0)
				addr_ok = idx < 8'(N_IN);
			else if ((a & rio_pkg::REG_BANK) == rio_pkg::REG_OUT0)
				addr_ok = idx < 8'(N_OUT);
		end
	endfunction

	function automatic logic [31:0] rd_data(input rio_state_t s, input logic [7:0] a);
		logic [7:0] m;
		logic [1:0] idx;
		m = base_word(s.cfg.unit);
		idx = a[3:2];
		rd_data = 32'h0;
		if (addr_ok(a))
		begin
			case (a & rio_pkg::REG_BANK)
				rio_pkg::REG_IN0:  rd_data = {16'h0, s.in_word[idx]};
				rio_pkg::REG_OUT0: rd_data = {16'h0, s.out_word[idx]};
				default:
				begin
					case (a)
						rio_pkg::REG_CFG:  rd_data = {m + 8'(N_OUT), m, 7'h0, s.cfg};
						rio_pkg::REG_STS:  rd_data = 32'(s.sts);
						rio_pkg::REG_MASK: rd_data = 32'(s.mask);
						rio_pkg::REG_STAT: rd_data = 32'({s.fbit_lamp, s.clr_lamp,
							s.fast_lamp, s.fault_lamp, s.seen, s.fault});
						default:           rd_data = 32'h0;
					endcase
				end
			endcase
		end
	endfunction

	logic [N_IN-1:0] good;
	logic            wr_en;
	logic            cfg_bad;

	always_comb
	begin
		logic [CW-1:0] limit;
		logic [15:0]   d;
		logic [STS_W-1:0] set;
		logic [STS_W-1:0] w1c;
		rio_pkg::rio_cfg_t cap;
		limit = '0;
		d = 16'h0;
		set = '0;
		w1c = '0;
		cap = st_r.cfg;
		st_nxt = st_r;
		good = '0;
		wr_en = i_psel && i_penable && i_pwrite && addr_ok(i_paddr);
		cfg_bad = 1'b0;
		st_nxt.sw1 = {i_unit_sw, i_dip_sw};
		st_nxt.sw2 = st_r.sw1;

		case (st_r.phase)
			rio_pkg::PH_SYNC:
			begin
				// Switches are caught once, after two sync stages have filled
				if (st_r.cap_cnt == rio_pkg::SYNC_DONE)
				begin
					cap.unit    = st_r.sw2[8:5];
					cap.fast    = st_r.sw2[rio_pkg::SW_FAST];
					cap.clr     = st_r.sw2[rio_pkg::SW_CLR];
					cap.fbit    = st_r.sw2[rio_pkg::SW_FBIT];
					cap.lamp_en = {st_r.sw2[rio_pkg::SW_EN2], st_r.sw2[rio_pkg::SW_EN1]};
					st_nxt.cfg = cap;
					// A unit past 9, or a four-word unit on 9, overruns the area
					cfg_bad = (cap.unit > rio_pkg::UNIT_MAX) ||
						(base_word(cap.unit) + 8'(N_IN + N_OUT - 1) >
						rio_pkg::WORD_AREA_LAST);
					st_nxt.phase = rio_pkg::PH_RUN;
				end
				else
				begin
					st_nxt.cap_cnt = st_r.cap_cnt + 2'h1;
				end
			end
			rio_pkg::PH_RUN:
			begin
				for (int i = 0; i < N_IN; i++)
				begin
					// Until the first good frame the startup window applies
					if (!st_r.seen[i])
						limit = CW'(STARTUP_CYC);
					else if (st_r.cfg.fast)
						limit = CW'(LOSS_FAST_CYC);
					else
						limit = CW'(LOSS_STD_CYC);
					good[i] = i_rx_stb[i] && !i_rx_err[i] &&
						(i_rx_fast[i] == st_r.cfg.fast);
					if (good[i])
					begin
						st_nxt.fault[i] = 1'b0;
						st_nxt.seen[i] = 1'b1;
						st_nxt.tmo[i] = '0;
						set[N_IN + i] = st_r.fault[i];
					end
					else
					begin
						if (i_rx_stb[i] || st_r.tmo[i] >= limit)
							st_nxt.fault[i] = 1'b1;
						if (st_r.tmo[i] < limit)
							st_nxt.tmo[i] = st_r.tmo[i] + CW'(1);
						set[i] = st_nxt.fault[i] && !st_r.fault[i];
					end
					if (good[i])
						d = i_rx_data[i];
					else if (!st_r.seen[i] || (st_nxt.fault[i] && st_r.cfg.clr))
						d = 16'h0;
					else
						d = st_r.in_word[i];
					if (st_r.cfg.fbit)
						d[rio_pkg::FLAG_BIT] = st_nxt.fault[i];
					st_nxt.in_word[i] = d;
					// Lamp and flag leave on the same edge as the word
					st_nxt.fault_lamp[i] = st_nxt.fault[i] && st_r.cfg.lamp_en[i];
				end
			end
			default:
			begin
				st_nxt.phase = rio_pkg::PH_SYNC;
			end
		endcase

		st_nxt.fast_lamp = st_nxt.cfg.fast;
		st_nxt.clr_lamp  = st_nxt.cfg.clr;
		st_nxt.fbit_lamp = st_nxt.cfg.fbit;
		set[2 * N_IN] = cfg_bad;

		if (wr_en && i_paddr == rio_pkg::REG_STS)
			w1c = i_pwdata[STS_W-1:0];
		if (wr_en && i_paddr == rio_pkg::REG_MASK)
			st_nxt.mask = i_pwdata[STS_W-1:0];
		if (wr_en && (i_paddr & rio_pkg::REG_BANK) == rio_pkg::REG_OUT0)
			st_nxt.out_word[i_paddr[3:2]] = i_pwdata[15:0];
		// A new event beats a clear in the same cycle
		st_nxt.sts = (st_r.sts & ~w1c) | set;

		// Read data is latched in the setup cycle so it leaves from a flop
		if (i_psel && !i_penable)
			st_nxt.prdata = rd_data(st_r, i_paddr);
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			st_r <= '{phase: rio_pkg::PH_SYNC, cfg: rio_pkg::CFG_RESET, default: '0};
		end
		else
		begin
			st_r <= st_nxt;
		end
	end

	// Output links carry data only; their faults show at the terminal
	assign o_tx_word             = st_r.out_word;
	assign o_tx_fast             = st_r.cfg.fast;
	assign o_in_word             = st_r.in_word;
	assign o_fault_lamp          = st_r.fault_lamp;
	assign o_fast_delay_lamp     = st_r.fast_lamp;
	assign o_clear_lamp          = st_r.clr_lamp;
	assign o_fault_bit_mode_lamp = st_r.fbit_lamp;
	assign o_irq                 = |(st_r.sts & st_r.mask);
	assign o_prdata              = st_r.prdata;
	assign o_pready              = 1'b1;
	assign o_pslverr             = i_psel && i_penable && !addr_ok(i_paddr);

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);

	logic run;
	assign run = st_r.phase == rio_pkg::PH_RUN;

	sequence mismatch_s;
		run && i_rx_stb[0] && !i_rx_err[0] && (i_rx_fast[0] != st_r.cfg.fast);
	endsequence
	sequence good_frame_s;
		run && good[0];
	endsequence

	delay_mismatch_a: assert property (mismatch_s |=> st_r.fault[0] &&
		o_fault_lamp[0] == st_r.cfg.lamp_en[0]) else $error("mismatch not a fault");
	recover_load_a: assert property (good_frame_s |=> !st_r.fault[0] &&
		o_in_word[0][14:0] == $past(i_rx_data[0][14:0])) else $error("recovery wrong");
	// A bad frame during startup is a fault of its own, so only silence is checked here
	startup_flag_a: assert property (run && !st_r.seen[0] && !st_r.fault[0] && !i_rx_stb[0] &&
		st_r.tmo[0] < CW'(STARTUP_CYC) - CW'(1)
		|=> !st_r.fault[0]) else $error("flag set too early");
	no_input_a: assert property (!st_r.seen[0] |-> o_in_word[0][14:0] == 15'h0)
		else $error("inputs before first frame");
	clear_inputs_a: assert property (run && st_r.cfg.clr && st_r.fault[0]
		|-> o_in_word[0][14:0] == 15'h0) else $error("inputs not cleared");
	hold_inputs_a: assert property (run && !st_r.cfg.clr && !good[0] ##1 st_r.fault[0]
		|-> o_in_word[0][14:0] == $past(o_in_word[0][14:0])) else $error("inputs not held");
	flag_bit_a: assert property (run && st_r.cfg.fbit
		|-> o_in_word[0][15] == st_r.fault[0]) else $error("flag bit wrong");
	lamp_gate_a: assert property (o_fault_lamp[0] |-> st_r.cfg.lamp_en[0] && st_r.fault[0])
		else $error("fault lamp not gated");
	unit_frozen_a: assert property (run |=> run && $stable(st_r.cfg))
		else $error("config changed while running");
	reset_cfg_a: assert property (!run |-> st_r.cfg == rio_pkg::CFG_RESET)
		else $error("config not at default before capture");
	mode_lamps_a: assert property (run |-> o_fast_delay_lamp == o_tx_fast &&
		o_clear_lamp == st_r.cfg.clr && o_fault_bit_mode_lamp == st_r.cfg.fbit)
		else $error("mode lamp wrong");

endmodule
